// [logic/sclv_loader.v]
// configuration loader: eeprom reader, configuration store and switching controls
`include "sclv_defines.vh"
`default_nettype none

// Behaviour
// - per-port membership mask, port 0 at 13
// - multicast and broadcast always follow ingress mask
// - general bit 0 enforces mask on unicast
// - port bit 2 inserts tag when missing
// - port bit 1 strips existing tag
// - insertion value from per-port tag bytes
// - bytes 48-53 are control frame source
// - eeprom reached by clock and data pins
// - each eeprom byte stored at same address
// - accept only signature 55 then 99
// - start: data falls while clock high
// - stop: data rises while clock high
// - data otherwise changes only while clock low
// - general bits 3-2 select priority interleave
// - general bit 1 reserves high priority buffer
// - byte 3 bit k marks tag value k high
// - port bits 5 and 4 enable classifiers
// - port bit 3 high, bit 0 queue split
// - dscp code point looked up in 64-bit map
module sclv_loader #(
	parameter QTR_CYC = `SCLV_EE_QTR_CYC
) (
	// clock and reset
	input  wire        mclk,
	input  wire        rstn,
	// eeprom pins
	output wire        ee_scl,
	input  wire        ee_sda_in,
	output wire        ee_sda_out,
	output wire        ee_sda_oe,
	// load status
	output wire        load_done,
	output wire        cfg_valid,
	output wire        sig_err,
	output wire        ack_err,
	output wire        switch_en,
	// forwarding
	input  wire [2:0]  fwd_src_port,
	input  wire        fwd_unicast,
	input  wire [7:0]  fwd_lookup_mask,
	output wire [7:0]  fwd_port_mask,
	// tag handling
	input  wire [2:0]  tag_port,
	input  wire        tag_frame_tagged,
	output wire        tag_insert,
	output wire        tag_strip,
	output wire [15:0] tag_value,
	// priority
	input  wire [2:0]  prio_port,
	input  wire        prio_tagged,
	input  wire [2:0]  prio_tag_pri,
	input  wire        prio_ipv4,
	input  wire [5:0]  prio_dscp,
	output wire        prio_high,
	// global settings
	output wire [1:0]  prio_interleave,
	output wire        prio_buf_reserve,
	output wire [7:0]  queue_split,
	output wire [47:0] station_mac
);

	localparam ST_IDLE  = 3'b000;
	localparam ST_START = 3'b001;
	localparam ST_SEND  = 3'b010;
	localparam ST_RECV  = 3'b011;
	localparam ST_STOP  = 3'b100;
	localparam ST_DONE  = 3'b101;

	localparam integer QTR_LOAD_I = QTR_CYC - 1;
	localparam [7:0]   QTR_LOAD   = QTR_LOAD_I[7:0];

	// default image value of each configuration byte
	function [7:0] def_byte;
		input integer a;
		begin
			if (a == `SCLV_SIG_FIRST_ADDR)
				def_byte = `SCLV_SIG_FIRST_VAL;
			else if (a == `SCLV_SIG_SECOND_ADDR)
				def_byte = `SCLV_SIG_SECOND_VAL;
			else if (a == `SCLV_TAG_MAP_ADDR)
				def_byte = `SCLV_TAG_MAP_RST;
			else if (a >= `SCLV_VLAN_MASK_ADDR && a < `SCLV_VLAN_MASK_ADDR + 8)
				def_byte = `SCLV_VLAN_MASK_RST;
			else
				def_byte = 8'h00;
		end
	endfunction

	reg  [2:0]  state_ff;
	reg  [1:0]  phase_ff;
	reg  [3:0]  bit_ff;
	reg  [1:0]  step_ff;
	reg  [7:0]  shift_ff;
	reg  [5:0]  addr_ff;
	reg  [7:0]  qtr_ff;
	reg         scl_ff;
	reg         drv_low_ff;
	reg         done_ff;
	reg         cfg_ok_ff;
	reg         sig_err_ff;
	reg         ack_err_ff;
	reg  [7:0]  mem [0:`SCLV_CFG_BYTES-1];
	wire        sda_s;
	wire        tick;
	wire        sig_bad;
	wire        last_byte;
	wire [7:0]  eff [0:`SCLV_CFG_BYTES-1];
	integer     i;

	sclv_sync u_sda_sync (
		.mclk     (mclk),
		.rstn     (rstn),
		.async_in (ee_sda_in),
		.sync_out (sda_s)
	);

	assign tick = (qtr_ff == 8'h00);

	assign sig_bad = ((addr_ff == `SCLV_SIG_FIRST_ADDR) && (shift_ff != `SCLV_SIG_FIRST_VAL)) ||
		((addr_ff == `SCLV_SIG_SECOND_ADDR) && (shift_ff != `SCLV_SIG_SECOND_VAL));
	assign last_byte = (addr_ff == `SCLV_CFG_LAST) || sig_bad;

	// quarter-bit timebase for the eeprom clock
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			qtr_ff <= 8'h00;
		end else if (tick) begin
			qtr_ff <= QTR_LOAD;
		end else begin
			qtr_ff <= qtr_ff - 8'h01;
		end
	end

	// eeprom read sequencer, one action per quarter bit
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_ff   <= ST_IDLE;
			phase_ff   <= 2'b00;
			bit_ff     <= 4'h0;
			step_ff    <= 2'b00;
			shift_ff   <= 8'h00;
			addr_ff    <= 6'h00;
			scl_ff     <= 1'b1;
			drv_low_ff <= 1'b0;
			done_ff    <= 1'b0;
			cfg_ok_ff  <= 1'b0;
			sig_err_ff <= 1'b0;
			ack_err_ff <= 1'b0;
			for (i = 0; i < `SCLV_CFG_BYTES; i = i + 1)
				mem[i] <= 8'h00;
		end else if (tick) begin
			phase_ff <= phase_ff + 2'b01;
			case (state_ff)
				ST_IDLE: begin
					state_ff <= ST_START;
					phase_ff <= 2'b00;
					step_ff  <= 2'b00;
					shift_ff <= `SCLV_EE_CTRL_WR;
				end
				ST_START: begin
					case (phase_ff)
						2'b00: drv_low_ff <= 1'b0;
						2'b01: scl_ff <= 1'b1;
						2'b10: drv_low_ff <= 1'b1;
						default: begin
							scl_ff   <= 1'b0;
							state_ff <= ST_SEND;
							bit_ff   <= 4'h0;
						end
					endcase
				end
				ST_SEND: begin
					case (phase_ff)
						2'b00: drv_low_ff <= (bit_ff < 4'h8) ? ~shift_ff[7] : 1'b0;
						2'b01: scl_ff <= 1'b1;
						2'b10: scl_ff <= 1'b1;
						default: begin
							scl_ff <= 1'b0;
							if (bit_ff < 4'h8) begin
								shift_ff <= {shift_ff[6:0], 1'b0};
								bit_ff   <= bit_ff + 4'h1;
							end else if (sda_s) begin
								ack_err_ff <= 1'b1;
								state_ff   <= ST_STOP;
							end else begin
								bit_ff <= 4'h0;
								case (step_ff)
									2'b00: begin
										shift_ff <= `SCLV_EE_START_ADDR;
										step_ff  <= 2'b01;
									end
									2'b01: begin
										shift_ff <= `SCLV_EE_CTRL_RD;
										step_ff  <= 2'b10;
										state_ff <= ST_START;
									end
									default: begin
										state_ff <= ST_RECV;
										addr_ff  <= 6'h00;
									end
								endcase
							end
						end
					endcase
				end
				ST_RECV: begin
					case (phase_ff)
						2'b00: drv_low_ff <= (bit_ff == 4'h8) ? ~last_byte : 1'b0;
						2'b01: scl_ff <= 1'b1;
						2'b10: begin
							if (bit_ff < 4'h8)
								shift_ff <= {shift_ff[6:0], sda_s};
						end
						default: begin
							scl_ff <= 1'b0;
							if (bit_ff < 4'h8) begin
								bit_ff <= bit_ff + 4'h1;
								if (bit_ff == 4'h7)
									mem[addr_ff] <= shift_ff;
							end else if (last_byte) begin
								sig_err_ff <= sig_bad;
								cfg_ok_ff  <= ~sig_bad;
								state_ff   <= ST_STOP;
							end else begin
								addr_ff <= addr_ff + 6'h01;
								bit_ff  <= 4'h0;
							end
						end
					endcase
				end
				ST_STOP: begin
					case (phase_ff)
						2'b00: drv_low_ff <= 1'b1;
						2'b01: scl_ff <= 1'b1;
						2'b10: drv_low_ff <= 1'b0;
						default: begin
							state_ff <= ST_DONE;
							done_ff  <= 1'b1;
						end
					endcase
				end
				ST_DONE: begin
					state_ff <= ST_DONE;
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// open-drain data: only ever pulls low
	assign ee_scl     = scl_ff;
	assign ee_sda_out = 1'b0;
	assign ee_sda_oe  = drv_low_ff;

	assign load_done = done_ff;
	assign cfg_valid = cfg_ok_ff;
	assign sig_err   = sig_err_ff;
	assign ack_err   = ack_err_ff;
	assign switch_en = done_ff;

	// effective configuration: defaults unless a good image was loaded
	genvar g;
	generate
		for (g = 0; g < `SCLV_CFG_BYTES; g = g + 1) begin : g_eff
			assign eff[g] = cfg_ok_ff ? mem[g] : def_byte(g);
		end
	endgenerate

	wire [7:0]  gen_ctrl;
	wire [7:0]  tag_map;
	wire [63:0] dscp_map;
	wire [5:0]  mask_idx;
	wire [5:0]  fwd_ctrl_idx;
	wire [5:0]  tag_ctrl_idx;
	wire [5:0]  tag_val_idx;
	wire [5:0]  prio_ctrl_idx;
	wire [7:0]  src_mask;
	wire [7:0]  tag_ctrl;
	wire        prio_is_high;

	assign gen_ctrl      = eff[`SCLV_GEN_CTRL_ADDR];
	assign tag_map       = eff[`SCLV_TAG_MAP_ADDR];
	assign mask_idx      = `SCLV_VLAN_MASK_ADDR + {3'b000, fwd_src_port};
	assign fwd_ctrl_idx  = `SCLV_PORT_CTRL_ADDR + {3'b000, fwd_src_port};
	assign tag_ctrl_idx  = `SCLV_PORT_CTRL_ADDR + {3'b000, tag_port};
	assign tag_val_idx   = `SCLV_TAG_VAL_ADDR + {2'b00, tag_port, 1'b0};
	assign prio_ctrl_idx = `SCLV_PORT_CTRL_ADDR + {3'b000, prio_port};
	assign src_mask      = eff[mask_idx];
	assign tag_ctrl      = eff[tag_ctrl_idx];

	generate
		for (g = 0; g < 8; g = g + 1) begin : g_port
			assign dscp_map[g*8 +: 8] = eff[`SCLV_DSCP_ADDR + g];
			assign queue_split[g] = eff[`SCLV_PORT_CTRL_ADDR + g][`SCLV_PC_QSPLIT_BIT];
		end
	endgenerate

	sclv_prio u_prio (
		.port_ctrl    (eff[prio_ctrl_idx]),
		.tag_map      (tag_map),
		.dscp_map     (dscp_map),
		.frame_tagged (prio_tagged),
		.tag_pri      (prio_tag_pri),
		.frame_ipv4   (prio_ipv4),
		.dscp         (prio_dscp),
		.is_high      (prio_is_high)
	);

	reg  [7:0]  fwd_mask_ff;
	reg         tag_insert_ff;
	reg         tag_strip_ff;
	reg  [15:0] tag_value_ff;
	reg         prio_high_ff;

	// per-frame decisions, registered; nothing passes while switching is off
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fwd_mask_ff   <= 8'h00;
			tag_insert_ff <= 1'b0;
			tag_strip_ff  <= 1'b0;
			tag_value_ff  <= 16'h0000;
			prio_high_ff  <= 1'b0;
		end else if (!done_ff) begin
			fwd_mask_ff   <= 8'h00;
			tag_insert_ff <= 1'b0;
			tag_strip_ff  <= 1'b0;
			tag_value_ff  <= 16'h0000;
			prio_high_ff  <= 1'b0;
		end else begin
			if (!fwd_unicast)
				fwd_mask_ff <= fwd_lookup_mask & src_mask;
			else if (gen_ctrl[`SCLV_GC_ENFORCE_BIT])
				fwd_mask_ff <= fwd_lookup_mask & src_mask;
			else
				fwd_mask_ff <= fwd_lookup_mask;
			tag_insert_ff <= tag_ctrl[`SCLV_PC_INSERT_BIT] & ~tag_frame_tagged;
			tag_strip_ff  <= tag_ctrl[`SCLV_PC_STRIP_BIT] & tag_frame_tagged;
			if (tag_ctrl[`SCLV_PC_INSERT_BIT] & ~tag_frame_tagged)
				tag_value_ff <= {eff[tag_val_idx], eff[tag_val_idx + 6'h01]};
			else
				tag_value_ff <= 16'h0000;
			prio_high_ff <= prio_is_high;
		end
	end

	assign fwd_port_mask    = fwd_mask_ff;
	assign tag_insert       = tag_insert_ff;
	assign tag_strip        = tag_strip_ff;
	assign tag_value        = tag_value_ff;
	assign prio_high        = prio_high_ff;
	assign prio_interleave  = gen_ctrl[`SCLV_GC_SCHEME_LSB +: 2];
	assign prio_buf_reserve = gen_ctrl[`SCLV_GC_RESERVE_BIT];
	assign station_mac      = {eff[`SCLV_MAC_ADDR], eff[`SCLV_MAC_ADDR + 1],
		eff[`SCLV_MAC_ADDR + 2], eff[`SCLV_MAC_ADDR + 3],
		eff[`SCLV_MAC_ADDR + 4], eff[`SCLV_MAC_ADDR + 5]};

endmodule // sclv_loader

`default_nettype wire

// [common/sclv_defines.vh]
// constants for the serial configuration loader
`ifndef SCLV_DEFINES_VH
`define SCLV_DEFINES_VH

// timing
`define SCLV_CLK_PERIOD_NS    100
`define SCLV_EE_PERIOD_NS     10000
`define SCLV_EE_QTR_CYC       ((`SCLV_EE_PERIOD_NS / 4) / `SCLV_CLK_PERIOD_NS)

// two-wire eeprom framing
`define SCLV_EE_CTRL_WR       8'ha0
`define SCLV_EE_CTRL_RD       8'ha1
`define SCLV_EE_START_ADDR    8'h00

// configuration image
`define SCLV_CFG_BYTES        54
`define SCLV_CFG_LAST         6'h35
`define SCLV_SIG_FIRST_ADDR   6'h00
`define SCLV_SIG_SECOND_ADDR  6'h01
`define SCLV_SIG_FIRST_VAL    8'h55
`define SCLV_SIG_SECOND_VAL   8'h99
`define SCLV_GEN_CTRL_ADDR    2
`define SCLV_TAG_MAP_ADDR     3
`define SCLV_PORT_CTRL_ADDR   6'h04
`define SCLV_VLAN_MASK_ADDR   6'h0d
`define SCLV_TAG_VAL_ADDR     6'h16
`define SCLV_DSCP_ADDR        40
`define SCLV_MAC_ADDR         48

// reset values
`define SCLV_TAG_MAP_RST      8'hf0
`define SCLV_VLAN_MASK_RST    8'hff

// general control fields
`define SCLV_GC_ENFORCE_BIT   0
`define SCLV_GC_RESERVE_BIT   1
`define SCLV_GC_SCHEME_LSB    2

// port control fields
`define SCLV_PC_QSPLIT_BIT    0
`define SCLV_PC_STRIP_BIT     1
`define SCLV_PC_INSERT_BIT    2
`define SCLV_PC_PORTPRI_BIT   3
`define SCLV_PC_TAGPRI_BIT    4
`define SCLV_PC_TOS_BIT       5

`endif

// [logic/sclv_sync.v]
// two flip-flop synchroniser for a single asynchronous level
`default_nettype none

module sclv_sync (
	// clock and reset
	input  wire mclk,
	input  wire rstn,
	// level
	input  wire async_in,
	output wire sync_out
);

	reg meta_ff;
	reg sync_ff;

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule // sclv_sync

`default_nettype wire

// [logic/sclv_prio.v]
// priority classification of one frame from its ingress port settings
`include "sclv_defines.vh"
`default_nettype none

module sclv_prio (
	// settings of the ingress port and global maps
	input  wire [7:0]  port_ctrl,
	input  wire [7:0]  tag_map,
	input  wire [63:0] dscp_map,
	// frame attributes
	input  wire        frame_tagged,
	input  wire [2:0]  tag_pri,
	input  wire        frame_ipv4,
	input  wire [5:0]  dscp,
	// result
	output wire        is_high
);

	wire by_port;
	wire by_tag;
	wire by_tos;

	assign by_port = port_ctrl[`SCLV_PC_PORTPRI_BIT];
	assign by_tag  = port_ctrl[`SCLV_PC_TAGPRI_BIT] & frame_tagged & tag_map[tag_pri];
	assign by_tos  = port_ctrl[`SCLV_PC_TOS_BIT] & frame_ipv4 & dscp_map[dscp];
	assign is_high = by_port | by_tag | by_tos;

endmodule // sclv_prio

`default_nettype wire

// [dv/sclv_eeprom.sv]
// behavioural two-wire configuration eeprom
`default_nettype none
module sclv_eeprom (
	// link
	input  wire logic         scl,
	input  wire logic         sda,
	output var  logic         pull,
	// image and refusal
	input  wire logic [511:0] img,
	input  wire logic         nak
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	logic [5:0] adr;
	logic [3:0] cnt;
	logic       act;
	logic       txm;
	int         nb;
	initial begin
		pull = 1'b0;
		act = 1'b0;
		txm = 1'b0;
	end
	always @(negedge sda) if (scl) begin
		act = 1'b1;
		cnt = 4'h0;
		nb = 0;
		txm = 1'b0;
	end
	always @(posedge sda) if (scl) act = 1'b0;
	always @(posedge scl) if (act) begin
		if (cnt < 4'h8) sh = {sh[6:0], sda};
		else if (txm && sda) txm = 1'b0;
		cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
	end
	// the line only moves while the clock is low
	always @(negedge scl) begin
		pull = 1'b0;
		if (act && cnt == 4'h8 && !txm) begin
			pull = !nak;
			if (nb == 1) adr = sh[5:0];
			if (sh == 8'ha1) txm = 1'b1;
			nb = nb + 1;
		end else if (act && txm && cnt < 4'h8) pull = !img[{adr, 3'h7 - cnt[2:0]}];
		else if (act && txm) adr = adr + 6'h1;
	end
endmodule // sclv_eeprom
`default_nettype wire

// [dv/sclv_loader_asserts.sv]
// concurrent checks on the configuration loader ports
`default_nettype none
module sclv_loader_asserts #(
	parameter QTR_CYC = 2
) (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rstn,
	// eeprom link and status
	input wire logic        ee_scl,
	input wire logic        ee_sda_oe,
	input wire logic        load_done,
	input wire logic        cfg_valid,
	input wire logic        sig_err,
	input wire logic        switch_en,
	// decisions
	input wire logic        fwd_unicast,
	input wire logic        tag_frame_tagged,
	input wire logic        tag_insert,
	input wire logic        tag_strip,
	input wire logic [7:0]  fwd_lookup_mask,
	input wire logic [7:0]  fwd_port_mask,
	input wire logic [7:0]  queue_split,
	input wire logic [15:0] tag_value,
	input wire logic [1:0]  prio_interleave,
	input wire logic        prio_buf_reserve,
	input wire logic [47:0] station_mac
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STOP_W = 2 * QTR_CYC;
	// the stop condition takes four quarters after the abandon decision
	localparam int DONE_W = 4 * QTR_CYC;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	link_idle_a: assert property (load_done |-> ee_scl && !ee_sda_oe)
		else $error("link not idle after loading");
	stop_done_a: assert property ($fell(ee_sda_oe) && ee_scl |-> ##[1:STOP_W] load_done)
		else $error("release with clock high not followed by completion");
	sda_steady_a: assert property ($changed(ee_sda_oe) |-> $stable(ee_scl))
		else $error("data and clock moved together");
	scl_low_a: assert property ($fell(ee_scl) |-> !ee_scl [*4] ##1 ee_scl)
		else $error("clock low time wrong");
	gate_off_a: assert property (!switch_en |=> fwd_port_mask == 8'h00 && !tag_insert)
		else $error("decision while switching off");
	mcast_mask_a: assert property (switch_en && !fwd_unicast |=>
		(fwd_port_mask & ~$past(fwd_lookup_mask)) == 8'h00 &&
		(cfg_valid || fwd_port_mask == $past(fwd_lookup_mask)))
		else $error("port outside lookup or default mask applied");
	ucast_free_a: assert property (switch_en && fwd_unicast && !cfg_valid |=>
		fwd_port_mask == $past(fwd_lookup_mask)) else $error("default unicast masked");
	insert_untag_a: assert property (tag_insert |-> !$past(tag_frame_tagged))
		else $error("insert on tagged frame");
	strip_tag_a: assert property (tag_strip |-> $past(tag_frame_tagged))
		else $error("strip on untagged frame");
	value_gate_a: assert property (!tag_insert |-> tag_value == 16'h0000)
		else $error("tag value without insert");
	cfg_default_a: assert property (!cfg_valid |->
		{prio_interleave, prio_buf_reserve, queue_split, station_mac} == 59'h0)
		else $error("non default setting without valid image");
	sig_abandon_a: assert property (sig_err |-> !cfg_valid ##[0:DONE_W] load_done)
		else $error("bad signature accepted or load not ended");
endmodule // sclv_loader_asserts
bind sclv_loader sclv_loader_asserts #(.QTR_CYC(QTR_CYC)) sclv_loader_asserts_i (.mclk, .rstn,
	.ee_scl, .ee_sda_oe, .load_done, .cfg_valid, .sig_err, .switch_en, .fwd_unicast,
	.tag_frame_tagged, .tag_insert, .tag_strip, .fwd_lookup_mask, .fwd_port_mask, .queue_split,
	.tag_value, .prio_interleave, .prio_buf_reserve, .station_mac);
`default_nettype wire

// [dv/sclv_loader_bench.sv]
// testbench for the serial configuration loader
`default_nettype none
module sclv_loader_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0] port; logic uni; logic [7:0] lkp; logic tagd; logic [2:0] pri; logic ip;
		logic [5:0] dscp; logic [7:0] x_mask; logic x_ins; logic x_strip; logic [15:0] x_val;
		logic x_high;
	} sclv_row_t;
	logic         mclk, rstn, ee_scl, ee_sda_in, ee_sda_out, ee_sda_oe, pull, nak;
	logic         load_done, cfg_valid, sig_err, ack_err, switch_en, fwd_unicast;
	logic         tag_frame_tagged, tag_insert, tag_strip, prio_tagged, prio_ipv4, prio_high;
	logic         prio_buf_reserve;
	logic [2:0]   fwd_src_port, tag_port, prio_port, prio_tag_pri;
	logic [5:0]   prio_dscp;
	logic [7:0]   fwd_lookup_mask, fwd_port_mask, queue_split;
	logic [1:0]   prio_interleave;
	logic [15:0]  tag_value;
	logic [47:0]  station_mac;
	logic [511:0] img;
	int           err_count, n_tests, cyc;
	sclv_row_t    rows [6];
	// open-drain data line with pull-up
	assign ee_sda_in = ee_sda_oe ? ee_sda_out : !pull;
	sclv_loader #(.QTR_CYC(2)) sclv_loader_i (.mclk, .rstn, .ee_scl, .ee_sda_in, .ee_sda_out,
		.ee_sda_oe, .load_done, .cfg_valid, .sig_err, .ack_err, .switch_en, .fwd_src_port,
		.fwd_unicast, .fwd_lookup_mask, .fwd_port_mask, .tag_port, .tag_frame_tagged,
		.tag_insert, .tag_strip, .tag_value, .prio_port, .prio_tagged, .prio_tag_pri,
		.prio_ipv4, .prio_dscp, .prio_high, .prio_interleave, .prio_buf_reserve, .queue_split,
		.station_mac);
	sclv_eeprom sclv_eeprom_i (.scl(ee_scl), .sda(ee_sda_in), .pull, .img, .nak);
	initial mclk = 1'b0;
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// reset, then one complete load of the test image
	task automatic load(input logic [7:0] gen, input logic [7:0] sig2, input logic refuse);
		int k;
		nak = refuse;
		img = 512'h0;
		img[31:0] = {8'h0f, gen, sig2, 8'h55};
		img[55:32] = 24'h092214;
		img[8*13 +: 16] = 16'h0182;
		img[8*20 +: 8] = 8'h40;
		img[8*22 +: 16] = 16'h3412;
		img[8*45 +: 8] = 8'h08;
		img[8*48 +: 48] = 48'h151413121110;
		rstn = 1'b0;
		repeat (16) @(negedge mclk);
		chk("reset mac", station_mac, 48'h0);
		rstn = 1'b1;
		@(negedge mclk);
		chk("switch_en", switch_en, 1'b0);
		for (k = 0; k < 6000 && load_done !== 1'b1; k++) @(negedge mclk);
		chk("load_done", load_done, 1'b1);
	endtask
	initial begin
		int g;
		{rstn, nak, fwd_src_port, fwd_unicast, fwd_lookup_mask, tag_port} = 17'h0;
		{tag_frame_tagged, prio_port, prio_tagged, prio_tag_pri, prio_ipv4, prio_dscp} = 15'h0;
		{err_count, n_tests} = 64'h0;
		rows[0] = '{3'h0, 1'b0, 8'hff, 1'b0, 3'h0, 1'b0, 6'h00, 8'h82, 1'b1, 1'b0, 16'h1234, 1'b0};
		rows[1] = '{3'h0, 1'b1, 8'h0f, 1'b1, 3'h2, 1'b0, 6'h00, 8'h02, 1'b0, 1'b0, 16'h0, 1'b1};
		rows[2] = '{3'h1, 1'b1, 8'hff, 1'b1, 3'h6, 1'b1, 6'h2b, 8'h01, 1'b0, 1'b1, 16'h0, 1'b1};
		rows[3] = '{3'h1, 1'b0, 8'hfe, 1'b0, 3'h0, 1'b1, 6'h2a, 8'h00, 1'b0, 1'b0, 16'h0, 1'b0};
		rows[4] = '{3'h2, 1'b1, 8'h55, 1'b0, 3'h0, 1'b0, 6'h00, 8'h00, 1'b0, 1'b0, 16'h0, 1'b1};
		rows[5] = '{3'h7, 1'b0, 8'hff, 1'b1, 3'h7, 1'b0, 6'h00, 8'h40, 1'b0, 1'b0, 16'h0, 1'b0};
		for (g = 0; g < 4; g++) begin
			load({4'h0, g[1:0], g[0], g[1]}, 8'h99, 1'b0);
			chk("cfg_valid", cfg_valid, 1'b1);
			chk("interleave", prio_interleave, g[1:0]);
			chk("reserve", prio_buf_reserve, g[0]);
			chk("queue_split", queue_split, 8'h04);
			chk("station_mac", station_mac, 48'h101112131415);
			$display("load with scheme %0d done", g);
		end
		foreach (rows[i]) begin
			{fwd_src_port, tag_port, prio_port} = {3{rows[i].port}};
			{fwd_unicast, fwd_lookup_mask} = {rows[i].uni, rows[i].lkp};
			{tag_frame_tagged, prio_tagged} = {2{rows[i].tagd}};
			{prio_tag_pri, prio_ipv4, prio_dscp} = {rows[i].pri, rows[i].ip, rows[i].dscp};
			@(negedge mclk);
			chk("port mask", fwd_port_mask, rows[i].x_mask);
			chk("tag ops", {tag_insert, tag_strip}, {rows[i].x_ins, rows[i].x_strip});
			chk("tag value", tag_value, rows[i].x_val);
			chk("priority", prio_high, rows[i].x_high);
		end
		$display("decision table done");
		load(8'h0d, 8'h98, 1'b0);
		chk("sig_err", sig_err, 1'b1);
		chk("defaults", {cfg_valid, prio_interleave, station_mac}, 51'h0);
		{fwd_src_port, fwd_unicast, fwd_lookup_mask} = {3'h0, 1'b1, 8'h5a};
		@(negedge mclk);
		chk("unicast default", fwd_port_mask, 8'h5a);
		fwd_unicast = 1'b0;
		{prio_tagged, prio_tag_pri, prio_ipv4, prio_dscp} = {1'b1, 3'h7, 1'b1, 6'h2b};
		@(negedge mclk);
		chk("multicast default", fwd_port_mask, 8'h5a);
		chk("classifiers off", prio_high, 1'b0);
		$display("bad signature done");
		load(8'h0d, 8'h99, 1'b1);
		chk("ack_err", {ack_err, cfg_valid}, 2'b10);
		$display("refused load done");
		finish_test();
	end
endmodule // sclv_loader_bench
`default_nettype wire
